// >>> src/srb_pkg.sv
// Function
// - sixteen-bit stack pointer addresses top of stack
// - pop reads low byte, then high byte
// - push decrements, writes high, decrements, writes low
// - pair select: zero, one, two, accum/flags
// - pop pair and exit: 4,3,3 T-states
// - push pair, true exit: 5,3,3 T-states
// - false conditional exit: one cycle, five T-states
// - push index register: 4,5,3,3 T-states
// - pop second index register: 4,4,3,3 T-states
// - these instructions leave flags unchanged, except pop into accum/flags, which loads them
// - bit clear zeroes one operand bit
// - bit clear decode from prefixes and fields
// - bit index selects bit, zero is lsb
// - bit clear timing 23, 15, 8 T-states
// - exit pops program counter low then high
// - false exit leaves stack, advances counter
// - condition field tests zero, carry, parity, sign
// - register field decodes b,c,d,e,h,l,a
package srb_pkg;
	// axi-lite register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OPCODE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_SP = 8'h0c;
	localparam logic [7:0] ADDR_PC = 8'h10;
	localparam logic [7:0] ADDR_BC = 8'h14;
	localparam logic [7:0] ADDR_DE = 8'h18;
	localparam logic [7:0] ADDR_HL = 8'h1c;
	localparam logic [7:0] ADDR_AF = 8'h20;
	localparam logic [7:0] ADDR_IX = 8'h24;
	localparam logic [7:0] ADDR_IY = 8'h28;
	localparam logic [7:0] ADDR_TSTATES = 8'h2c;
	localparam logic [7:0] ADDR_MEM_ADDR = 8'h30;
	localparam logic [7:0] ADDR_MEM_DATA = 8'h34;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	// opcode prefixes and bases
	localparam logic [7:0] PFX_BIT = 8'hcb;
	localparam logic [7:0] PFX_IDX1 = 8'hdd;
	localparam logic [7:0] PFX_IDX2 = 8'hfd;
	localparam logic [7:0] OP_EXIT = 8'hc9;
	localparam logic [7:0] OP_IDX_POP = 8'he1;
	localparam logic [7:0] OP_IDX_PUSH = 8'he5;
	localparam logic [2:0] FIELD_MEM = 3'h6;
	localparam logic [1:0] PAT_CLEAR = 2'h2;
	// t-state totals
	localparam logic [5:0] T_POP = 6'h0a;
	localparam logic [5:0] T_PUSH = 6'h0b;
	localparam logic [5:0] T_EXIT_FALSE = 6'h05;
	localparam logic [5:0] T_IDX_PUSH = 6'h0f;
	localparam logic [5:0] T_IDX_POP = 6'h0e;
	localparam logic [5:0] T_CLR_IDX = 6'h17;
	localparam logic [5:0] T_CLR_MEM = 6'h0f;
	localparam logic [5:0] T_CLR_REG = 6'h08;
	// flag bit positions in the flag byte
	localparam int FLAG_S = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_PV = 2;
	localparam int FLAG_C = 0;
	localparam int MEM_AW = 16;
	typedef enum logic [1:0] {SRB_FMT_PLAIN, SRB_FMT_BIT, SRB_FMT_IDX} srb_fmt_t;
endpackage

// >>> src/srb_stack_mem.sv
// byte-wide memory standing for external stack/operand ram; read data registered
module srb_stack_mem (
	input wire logic aclk,
	// port
	input wire logic wen,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:(1 << srb_pkg::MEM_AW) - 1];

	always_ff @(posedge aclk) begin
		if (wen) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

// >>> src/srb_exec.sv
module srb_exec (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// status
	output logic busy
);
	typedef enum logic [3:0] {S_IDLE, S_RD_LO, S_RD_LO_W, S_RD_HI, S_RD_HI_W, S_WR_HI, S_WR_LO,
		S_OPR_W, S_OPR_WB, S_DONE} srb_state_t;

	srb_state_t state;
	logic [15:0] stack_pointer, program_counter, pair_zero, pair_one, pair_two, pair_accum_flags;
	logic [15:0] index_reg_first, index_reg_second;
	logic [7:0] op0, op1, op2, op3;
	logic [5:0] tstates;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata, lo_byte;
	logic mem_wen;
	logic [15:0] dbg_addr;
	logic [7:0] next_byte;

	// decoded fields of the instruction in flight
	logic [1:0] pair_select_field;
	logic [2:0] condition_field, bit_idx, opnd;
	logic is_idx, is_bit, use_second;
	logic [15:0] opnd_addr;

	assign is_idx = (op0 == srb_pkg::PFX_IDX1) || (op0 == srb_pkg::PFX_IDX2);
	assign use_second = (op0 == srb_pkg::PFX_IDX2);
	assign is_bit = (op0 == srb_pkg::PFX_BIT && op1[7:6] == srb_pkg::PAT_CLEAR) ||
		(is_idx && op1 == srb_pkg::PFX_BIT && op3[7:6] == srb_pkg::PAT_CLEAR && op3[2:0] == srb_pkg::FIELD_MEM);
	assign pair_select_field = op0[5:4];
	assign condition_field = op0[5:3];
	assign bit_idx = is_idx ? op3[5:3] : op1[5:3];
	assign opnd = op1[2:0];
	assign opnd_addr = is_idx ? (use_second ? index_reg_second : index_reg_first) + {{8{op2[7]}}, op2} : pair_two;

	function automatic logic cond_true(input logic [2:0] cf, input logic [7:0] f);
		logic bitv;
		bitv = 1'b0;
		unique case (cf[2:1])
			2'd0: bitv = f[srb_pkg::FLAG_Z];
			2'd1: bitv = f[srb_pkg::FLAG_C];
			2'd2: bitv = f[srb_pkg::FLAG_PV];
			2'd3: bitv = f[srb_pkg::FLAG_S];
		endcase
		return cf[0] ? bitv : !bitv;
	endfunction

	function automatic logic [15:0] pair_val(input logic [1:0] q, input logic [15:0] p0, input logic [15:0] p1,
		input logic [15:0] p2, input logic [15:0] p3);
		logic [15:0] v;
		v = p0;
		unique case (q)
			2'd0: v = p0;
			2'd1: v = p1;
			2'd2: v = p2;
			2'd3: v = p3;
		endcase
		return v;
	endfunction

	function automatic logic [7:0] reg_val(input logic [2:0] r, input logic [15:0] bc, input logic [15:0] de,
		input logic [15:0] hl, input logic [15:0] af);
		logic [7:0] v;
		v = 8'h00;
		unique case (r)
			3'd0: v = bc[15:8];
			3'd1: v = bc[7:0];
			3'd2: v = de[15:8];
			3'd3: v = de[7:0];
			3'd4: v = hl[15:8];
			3'd5: v = hl[7:0];
			3'd7: v = af[15:8];
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// clear selected bit, bit 0 is lsb
	function automatic logic [7:0] clr_bit(input logic [7:0] v, input logic [2:0] b);
		logic [7:0] m;
		m = 8'h01 << b;
		return v & ~m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// memory

	srb_stack_mem u_mem (
		.aclk(aclk),
		.wen(mem_wen),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// axi-lite slave

	logic aw_hold, w_hold, start, mem_poke;
	logic [7:0] aw_addr;
	logic [31:0] w_data;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
		end else begin
			s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready <= !w_hold && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (aw_hold && w_hold && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr[7:2] > srb_pkg::ADDR_MEM_DATA[7:2]) ? 2'b10 : 2'b00;
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_go;
	assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
	assign start = wr_go && aw_addr == srb_pkg::ADDR_CTRL && w_data[0] && state == S_IDLE;
	assign mem_poke = wr_go && aw_addr == srb_pkg::ADDR_MEM_DATA && state == S_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				unique case (s_axi_araddr)
					srb_pkg::ADDR_CTRL: s_axi_rdata <= 32'h0;
					srb_pkg::ADDR_OPCODE: s_axi_rdata <= {op3, op2, op1, op0};
					srb_pkg::ADDR_STATUS: s_axi_rdata <= {31'h0, busy};
					srb_pkg::ADDR_SP: s_axi_rdata <= {16'h0, stack_pointer};
					srb_pkg::ADDR_PC: s_axi_rdata <= {16'h0, program_counter};
					srb_pkg::ADDR_BC: s_axi_rdata <= {16'h0, pair_zero};
					srb_pkg::ADDR_DE: s_axi_rdata <= {16'h0, pair_one};
					srb_pkg::ADDR_HL: s_axi_rdata <= {16'h0, pair_two};
					srb_pkg::ADDR_AF: s_axi_rdata <= {16'h0, pair_accum_flags};
					srb_pkg::ADDR_IX: s_axi_rdata <= {16'h0, index_reg_first};
					srb_pkg::ADDR_IY: s_axi_rdata <= {16'h0, index_reg_second};
					srb_pkg::ADDR_TSTATES: s_axi_rdata <= {26'h0, tstates};
					srb_pkg::ADDR_MEM_ADDR: s_axi_rdata <= {16'h0, dbg_addr};
					srb_pkg::ADDR_MEM_DATA: s_axi_rdata <= {24'h0, mem_rdata};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// execution sequencer

	// memory port: sequencer owns it in its stack and operand states, otherwise software debug window
	always_comb begin
		mem_addr = dbg_addr;
		mem_wen = mem_poke;
		mem_wdata = w_data[7:0];
		unique case (state)
			S_RD_LO, S_RD_LO_W, S_RD_HI, S_RD_HI_W, S_WR_HI, S_WR_LO: begin
				mem_addr = stack_pointer;
				mem_wen = (state == S_WR_HI) || (state == S_WR_LO);
				mem_wdata = next_byte;
			end
			S_OPR_W, S_OPR_WB: begin
				mem_addr = opnd_addr;
				mem_wen = (state == S_OPR_WB);
				mem_wdata = clr_bit(mem_rdata, bit_idx);
			end
			default: begin
			end
		endcase
	end

	// byte to push: high half first, then low half
	logic [15:0] push_val;
	assign push_val = is_idx ? (use_second ? index_reg_second : index_reg_first) :
		pair_val(pair_select_field, pair_zero, pair_one, pair_two, pair_accum_flags);
	assign next_byte = (state == S_WR_HI) ? push_val[15:8] : push_val[7:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dbg_addr <= srb_pkg::RESET_WORD;
		end else if (wr_go && aw_addr == srb_pkg::ADDR_MEM_ADDR && state == S_IDLE) begin
			dbg_addr <= w_data[15:0];
		end
	end

	logic [15:0] popped;
	assign popped = {mem_rdata, lo_byte};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= S_IDLE;
			busy <= 1'b0;
			op0 <= 8'h00;
			op1 <= 8'h00;
			op2 <= 8'h00;
			op3 <= 8'h00;
			tstates <= 6'h00;
			lo_byte <= 8'h00;
			stack_pointer <= srb_pkg::RESET_WORD;
			program_counter <= srb_pkg::RESET_WORD;
			pair_zero <= srb_pkg::RESET_WORD;
			pair_one <= srb_pkg::RESET_WORD;
			pair_two <= srb_pkg::RESET_WORD;
			pair_accum_flags <= srb_pkg::RESET_WORD;
			index_reg_first <= srb_pkg::RESET_WORD;
			index_reg_second <= srb_pkg::RESET_WORD;
		end else begin
			unique case (state)
				S_IDLE: begin
					busy <= 1'b0;
					if (wr_go && aw_addr == srb_pkg::ADDR_OPCODE) begin
						{op3, op2, op1, op0} <= w_data;
					end else if (wr_go && aw_addr == srb_pkg::ADDR_SP) begin
						stack_pointer <= w_data[15:0];
					end else if (wr_go && aw_addr == srb_pkg::ADDR_PC) begin
						program_counter <= w_data[15:0];
					end else if (wr_go && aw_addr == srb_pkg::ADDR_BC) begin
						pair_zero <= w_data[15:0];
					end else if (wr_go && aw_addr == srb_pkg::ADDR_DE) begin
						pair_one <= w_data[15:0];
					end else if (wr_go && aw_addr == srb_pkg::ADDR_HL) begin
						pair_two <= w_data[15:0];
					end else if (wr_go && aw_addr == srb_pkg::ADDR_AF) begin
						pair_accum_flags <= w_data[15:0];
					end else if (wr_go && aw_addr == srb_pkg::ADDR_IX) begin
						index_reg_first <= w_data[15:0];
					end else if (wr_go && aw_addr == srb_pkg::ADDR_IY) begin
						index_reg_second <= w_data[15:0];
					end else if (start) begin
						busy <= 1'b1;
						state <= S_DONE;
						if (is_bit) begin
							if (is_idx) begin
								tstates <= srb_pkg::T_CLR_IDX;
								state <= S_OPR_W;
							end else if (opnd == srb_pkg::FIELD_MEM) begin
								tstates <= srb_pkg::T_CLR_MEM;
								state <= S_OPR_W;
							end else begin
								tstates <= srb_pkg::T_CLR_REG;
								unique case (opnd)
									3'd0: pair_zero[15:8] <= clr_bit(pair_zero[15:8], bit_idx);
									3'd1: pair_zero[7:0] <= clr_bit(pair_zero[7:0], bit_idx);
									3'd2: pair_one[15:8] <= clr_bit(pair_one[15:8], bit_idx);
									3'd3: pair_one[7:0] <= clr_bit(pair_one[7:0], bit_idx);
									3'd4: pair_two[15:8] <= clr_bit(pair_two[15:8], bit_idx);
									3'd5: pair_two[7:0] <= clr_bit(pair_two[7:0], bit_idx);
									3'd7: pair_accum_flags[15:8] <= clr_bit(reg_val(opnd, pair_zero,
										pair_one, pair_two, pair_accum_flags), bit_idx);
									default: begin
									end
								endcase
							end
						end else if (is_idx && op1 == srb_pkg::OP_IDX_POP) begin
							tstates <= srb_pkg::T_IDX_POP;
							state <= S_RD_LO;
						end else if (is_idx && op1 == srb_pkg::OP_IDX_PUSH) begin
							tstates <= srb_pkg::T_IDX_PUSH;
							stack_pointer <= stack_pointer - 16'h0001;
							state <= S_WR_HI;
						end else if (op0 == srb_pkg::OP_EXIT) begin
							tstates <= srb_pkg::T_POP;
							state <= S_RD_LO;
						end else if (op0[7:6] == 2'b11 && op0[2:0] == 3'b000) begin
							if (cond_true(condition_field, pair_accum_flags[7:0])) begin
								tstates <= srb_pkg::T_PUSH;
								state <= S_RD_LO;
							end else begin
								tstates <= srb_pkg::T_EXIT_FALSE;
								program_counter <= program_counter + 16'h0001;
							end
						end else if (op0[7:6] == 2'b11 && op0[3:0] == 4'h1) begin
							tstates <= srb_pkg::T_POP;
							state <= S_RD_LO;
						end else if (op0[7:6] == 2'b11 && op0[3:0] == 4'h5) begin
							tstates <= srb_pkg::T_PUSH;
							stack_pointer <= stack_pointer - 16'h0001;
							state <= S_WR_HI;
						end
					end
				end
				// low byte at pointer, then high; wraps
				S_RD_LO: state <= S_RD_LO_W;
				S_RD_LO_W: begin
					lo_byte <= mem_rdata;
					stack_pointer <= stack_pointer + 16'h0001;
					state <= S_RD_HI;
				end
				S_RD_HI: state <= S_RD_HI_W;
				S_RD_HI_W: begin
					stack_pointer <= stack_pointer + 16'h0001;
					state <= S_DONE;
					// only the target changes, flags byte only on accum pop
					if (is_idx) begin
						if (use_second) begin
							index_reg_second <= popped;
						end else begin
							index_reg_first <= popped;
						end
					// the plain exit opcode has bit 0 set too, so match the full pop nibble
					end else if (op0[3:0] == 4'h1) begin
						unique case (pair_select_field)
							2'd0: pair_zero <= popped;
							2'd1: pair_one <= popped;
							2'd2: pair_two <= popped;
							2'd3: pair_accum_flags <= popped;
						endcase
					end else begin
						program_counter <= popped;
					end
				end
				S_WR_HI: begin
					stack_pointer <= stack_pointer - 16'h0001;
					state <= S_WR_LO;
				end
				S_WR_LO: state <= S_DONE;
				S_OPR_W: state <= S_OPR_WB;
				S_OPR_WB: state <= S_DONE;
				S_DONE: begin
					busy <= 1'b0;
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> verif/srb_exec_checker.sv
module srb_exec_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	// status
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
	ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready too long");
	ar_answer_a: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	w_answer_a: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
	r_code_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
		else $error("bad read code");
	busy_end_a: assert property ($rose(busy) |-> ##[1:60] !busy) else $error("busy stuck");
	cover property ($fell(busy));
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property (s_axi_awready && s_axi_wready);
endmodule

// >>> verif/srb_axi_master.sv
module srb_axi_master (
	// clock
	input wire logic aclk,
	// write
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	output logic bready,
	// read
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 100ps;
	// answer strobes stay high so no strobe is toggled twice in one step
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'hf;
		wvalid = 1'b0;
		bready = 1'b1;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b1;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
	endtask
endmodule

// >>> verif/srb_exec_tb.sv
module srb_exec_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, busy;
	logic [7:0] awaddr, araddr, pf, ra, dsp;
	logic [31:0] wdata, rdata, r;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] sp, x, v, pc, af;
	logic [2:0] b;
	logic e;
	int fail_count, checks, seed;
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	srb_exec u_srb_exec (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .busy(busy));
	srb_axi_master u_srb_axi_master (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic taken(input logic [2:0] c, input logic [7:0] f);
		logic t;
		case (c[2:1])
			2'h0: t = f[srb_pkg::FLAG_Z];
			2'h1: t = f[srb_pkg::FLAG_C];
			2'h2: t = f[srb_pkg::FLAG_PV];
			default: t = f[srb_pkg::FLAG_S];
		endcase
		return c[0] ? t : !t;
	endfunction
	function automatic logic [7:0] clr(input logic [7:0] d, input logic [2:0] bi);
		return d & ~(8'h01 << bi);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_srb_axi_master.wr(a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		u_srb_axi_master.rd(a, r);
		chk(r, exp);
	endtask
	task automatic mw(input logic [15:0] a, input logic [7:0] d);
		wr(srb_pkg::ADDR_MEM_ADDR, {16'h0, a});
		wr(srb_pkg::ADDR_MEM_DATA, {24'h0, d});
	endtask
	task automatic mc(input logic [15:0] a, input logic [7:0] exp);
		wr(srb_pkg::ADDR_MEM_ADDR, {16'h0, a});
		rc(srb_pkg::ADDR_MEM_DATA, {24'h0, exp});
	endtask
	// status is read until the operation has ended; the watchdog bounds it
	task automatic run(input logic [31:0] op);
		wr(srb_pkg::ADDR_OPCODE, op);
		wr(srb_pkg::ADDR_CTRL, 32'h1);
		do u_srb_axi_master.rd(srb_pkg::ADDR_STATUS, r); while (r[0] !== 1'b0);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		conclude();
	end
	initial begin
		seed = 9190;
		fail_count = 0;
		checks = 0;
		aresetn = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(srb_pkg::ADDR_SP, {16'h0, srb_pkg::RESET_WORD});
		for (int q = 0; q < 4; q++) begin
			sp = (q == 0) ? 16'hffff : 16'($random(seed));
			x = 16'($random(seed));
			mw(sp, x[7:0]);
			mw(sp + 16'h1, x[15:8]);
			wr(srb_pkg::ADDR_SP, {16'h0, sp});
			run({24'h0, 2'h3, 2'(q), 4'h1});
			rc(srb_pkg::ADDR_BC + 8'(q * 4), {16'h0, x});
			v = sp + 16'h2;
			rc(srb_pkg::ADDR_SP, {16'h0, v});
			rc(srb_pkg::ADDR_TSTATES, 32'h0a);
			sp = (q == 1) ? 16'h0001 : 16'($random(seed));
			x = 16'($random(seed));
			wr(srb_pkg::ADDR_BC + 8'(q * 4), {16'h0, x});
			wr(srb_pkg::ADDR_SP, {16'h0, sp});
			run({24'h0, 2'h3, 2'(q), 4'h5});
			mc(sp - 16'h1, x[15:8]);
			mc(sp - 16'h2, x[7:0]);
			v = sp - 16'h2;
			rc(srb_pkg::ADDR_SP, {16'h0, v});
			rc(srb_pkg::ADDR_TSTATES, 32'h0b);
		end
		$display("pair push and pop done");
		for (int i = 0; i < 2; i++) begin
			pf = i ? srb_pkg::PFX_IDX2 : srb_pkg::PFX_IDX1;
			ra = i ? srb_pkg::ADDR_IY : srb_pkg::ADDR_IX;
			sp = 16'($random(seed));
			x = 16'($random(seed));
			wr(ra, {16'h0, x});
			wr(srb_pkg::ADDR_SP, {16'h0, sp});
			run({16'h0, srb_pkg::OP_IDX_PUSH, pf});
			mc(sp - 16'h1, x[15:8]);
			mc(sp - 16'h2, x[7:0]);
			rc(srb_pkg::ADDR_TSTATES, 32'h0f);
			wr(ra, 32'h0);
			run({16'h0, srb_pkg::OP_IDX_POP, pf});
			rc(ra, {16'h0, x});
			rc(srb_pkg::ADDR_SP, {16'h0, sp});
			rc(srb_pkg::ADDR_TSTATES, 32'h0e);
		end
		$display("index push and pop done");
		for (int k = 0; k < 17; k++) begin
			af = {8'($random(seed)), (k > 7) ? 8'hff : 8'h00};
			sp = 16'($random(seed));
			x = 16'($random(seed));
			pc = 16'($random(seed));
			mw(sp, x[7:0]);
			mw(sp + 16'h1, x[15:8]);
			wr(srb_pkg::ADDR_SP, {16'h0, sp});
			wr(srb_pkg::ADDR_AF, {16'h0, af});
			wr(srb_pkg::ADDR_PC, {16'h0, pc});
			run(k == 16 ? {24'h0, srb_pkg::OP_EXIT} : {24'h0, 2'h3, 3'(k), 3'h0});
			e = k == 16 || taken(3'(k), af[7:0]);
			v = e ? x : pc + 16'h1;
			rc(srb_pkg::ADDR_PC, {16'h0, v});
			v = e ? sp + 16'h2 : sp;
			rc(srb_pkg::ADDR_SP, {16'h0, v});
			rc(srb_pkg::ADDR_TSTATES, k == 16 ? 32'h0a : e ? 32'h0b : 32'h05);
			rc(srb_pkg::ADDR_AF, {16'h0, af});
		end
		$display("exits done");
		for (int n = 0; n < 8; n++) begin
			if (n == 6) continue;
			b = 3'(n);
			ra = n == 7 ? srb_pkg::ADDR_AF : srb_pkg::ADDR_BC + 8'(n / 2 * 4);
			x = 16'($random(seed)) | (16'h0101 << b);
			wr(ra, {16'h0, x});
			run({16'h0, srb_pkg::PAT_CLEAR, b, 3'(n), srb_pkg::PFX_BIT});
			v = (n == 7 || n % 2 == 0) ? {clr(x[15:8], b), x[7:0]} : {x[15:8], clr(x[7:0], b)};
			rc(ra, {16'h0, v});
			rc(srb_pkg::ADDR_TSTATES, 32'h08);
		end
		for (int j = 0; j < 3; j++) begin
			b = j == 0 ? 3'h6 : 3'($random(seed));
			dsp = j == 1 ? 8'h80 : 8'h7f;
			pf = j == 1 ? srb_pkg::PFX_IDX1 : srb_pkg::PFX_IDX2;
			ra = j == 0 ? srb_pkg::ADDR_HL : j == 1 ? srb_pkg::ADDR_IX : srb_pkg::ADDR_IY;
			x = 16'($random(seed));
			wr(ra, {16'h0, x});
			v = j == 0 ? x : x + {{8{dsp[7]}}, dsp};
			mw(v, 8'hff);
			if (j == 0) begin
				run({16'h0, srb_pkg::PAT_CLEAR, b, srb_pkg::FIELD_MEM, srb_pkg::PFX_BIT});
			end else begin
				run({srb_pkg::PAT_CLEAR, b, srb_pkg::FIELD_MEM, dsp, srb_pkg::PFX_BIT, pf});
			end
			mc(v, clr(8'hff, b));
			rc(srb_pkg::ADDR_TSTATES, j == 0 ? 32'h0f : 32'h17);
		end
		rc(8'h3c, 32'h0);
		chk({30'h0, rresp}, 32'h2);
		wr(8'h38, 32'h0);
		chk({30'h0, bresp}, 32'h2);
		$display("bit clear done");
		conclude();
	end
endmodule
bind srb_exec srb_exec_checker u_srb_exec_checker (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .busy(busy));
